// >>> core/self_diag_defs.vh
`ifndef SELF_DIAG_DEFS_VH
`define SELF_DIAG_DEFS_VH

// Diagnostic register indices on the remote read port
`define REG_OUT_FAULT_LOW      2'h0
`define REG_OUT_FAULT_HIGH     2'h1
`define REG_DIAG_THREE         2'h2
`define REG_INTERNAL_FAULT     2'h3

// Output fault low register layout
`define OFL_TRIP_LO_POS        2
`define OFL_ALARM_POS          10
`define OFL_TRIP_NINE_POS      15

// Alarm group numbering and default link mask (group two only)
`define GROUP_NONE             2'h0
`define GROUP_ONE              2'h1
`define GROUP_TWO              2'h2
`define GROUP_THREE            2'h3
`define FAIL_LINK_DEFAULT      3'h2

// Watchdog timing
`define WD_TIMEOUT_US          1000
`define WD_RESTART_PULSE_US    10
`define WD_RECOVER_US          5000
`define CLK_MHZ                40

// Event codes
`define EVT_FAULT_ON           8'h38
`define EVT_FAULT_OFF          8'h39

`endif

// >>> core/watchdog_supervisor.v
`timescale 1ns/1ps
`include "self_diag_defs.vh"

// Independent watchdog: restarts a silent controller and declares a permanent fault
module watchdog_supervisor
#(
	parameter TIMEOUT_CYC = `WD_TIMEOUT_US * `CLK_MHZ,
	parameter RECOVER_CYC = `WD_RECOVER_US * `CLK_MHZ
)
(
	input  wire        clk,
	input  wire        rst,
	input  wire        kick,
	input  wire        clear,
	output reg         restart_r,
	output reg         permanent_r
);

	localparam PULSE_CYC = `WD_RESTART_PULSE_US * `CLK_MHZ;
	localparam S_RUN     = 2'h0;
	localparam S_RESTART = 2'h1;
	localparam S_WAIT    = 2'h2;
	localparam S_DEAD    = 2'h3;

	reg [1:0]  state_r;     // Supervisor state
	reg [31:0] count_r;     // Cycles since last kick or state entry

	////////////////////////////////////////////////////////////////////////////////
	// Timeout, restart pulse and recovery window
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r     <= S_RUN;
			count_r     <= 32'h0000_0000;
			restart_r   <= 1'b0;
			permanent_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				S_RUN:
				begin
					// Kick resets the timer; silence past timeout forces restart
					if (kick)
						count_r <= 32'h0000_0000;
					else if (count_r >= TIMEOUT_CYC - 1)
					begin
						state_r   <= S_RESTART;
						count_r   <= 32'h0000_0000;
						restart_r <= 1'b1;
					end
					else
						count_r <= count_r + 32'h0000_0001;
				end
				S_RESTART:
				begin
					if (count_r >= PULSE_CYC - 1)
					begin
						state_r   <= S_WAIT;
						count_r   <= 32'h0000_0000;
						restart_r <= 1'b0;
					end
					else
						count_r <= count_r + 32'h0000_0001;
				end
				S_WAIT:
				begin
					// A kick inside the window means the controller came back
					if (kick)
					begin
						state_r <= S_RUN;
						count_r <= 32'h0000_0000;
					end
					else if (count_r >= RECOVER_CYC - 1)
					begin
						state_r     <= S_DEAD;
						permanent_r <= 1'b1;
					end
					else
						count_r <= count_r + 32'h0000_0001;
				end
				S_DEAD:
				begin
					// Only a local panel reset leaves the dead state
					if (clear)
					begin
						state_r     <= S_RUN;
						count_r     <= 32'h0000_0000;
						permanent_r <= 1'b0;
					end
				end
				default:
					state_r <= S_RUN;
			endcase
		end
	end

endmodule // watchdog_supervisor

// >>> core/self_supervision.v
`timescale 1ns/1ps
`include "self_diag_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module self_supervision
#(
	parameter TIMEOUT_CYC = `WD_TIMEOUT_US * `CLK_MHZ,
	parameter RECOVER_CYC = `WD_RECOVER_US * `CLK_MHZ
)
(
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST,
	// Controller supervision
	input  wire        CPU_KICK,
	output wire        CPU_RESTART,
	// Fault sources (pins, asynchronous)
	input  wire [23:0] TRIP_FAULT,
	input  wire [4:0]  ALARM_FAULT,
	input  wire [9:0]  INTERNAL_FAULT,
	input  wire        BOOT_TEST_FAIL,
	input  wire        MAIN_FUNC_LOST,
	// Alarm conditions (pins, asynchronous)
	input  wire        REMOTE_LINK_DOWN,
	input  wire        EXT_IO_LINK_DOWN,
	input  wire        PORT_ONE_DOWN,
	input  wire        PORT_TWO_DOWN,
	input  wire        PASSWORD_OPEN,
	input  wire        PANEL_RESET,
	// Configuration
	input  wire [29:0] ALARM_GROUP_SEL,
	input  wire        CFG_LOAD_DEFAULTS,
	input  wire [2:0]  FAIL_LINK_SET,
	input  wire        FAIL_LINK_WE,
	input  wire [32:0] GROUP_ONE_MAP,
	input  wire [32:0] GROUP_TWO_MAP,
	input  wire [32:0] GROUP_THREE_MAP,
	// Outputs requested by protection logic
	input  wire [32:0] OUT_REQUEST,
	// Driven relay outputs
	output reg  [32:0] OUT_DRIVE,
	output reg         FAIL_INDICATION_OUTPUT,
	output reg         SERVICE_LED,
	output reg         FAULT_MESSAGE,
	output reg  [8:0]  ALARM_SIGNALS,
	output reg  [2:0]  FAIL_LINK,
	// Event log
	output reg         EVENT_VALID,
	output reg  [7:0]  EVENT_CODE,
	output reg  [15:0] EVENT_FAULT_CODE,
	// Remote register read port
	input  wire [1:0]  REG_ADDR,
	output reg  [15:0] REG_RDATA
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	// Every pin-level input shares one synchroniser vector; positions are fixed
	// twice, by the concatenation order and by the hard-coded field views, so a
	// new pin shifts the fields above it unless the views change too
	wire [46:0] raw_in;            // All asynchronous inputs in one vector
	reg  [46:0] sync1_r;           // First synchroniser stage
	reg  [46:0] sync2_r;           // Second stage, the only one read
	wire [23:0] trip_f;            // Synchronised trip faults
	wire [4:0]  alarm_f;           // Synchronised alarm output faults
	wire [9:0]  int_f;             // Synchronised internal faults
	wire        boot_fail;         // Self-test failed
	wire        main_lost;         // Main functions cannot be handled
	wire [4:0]  link_alarm;        // Remote, extension, port one, port two, password
	wire        panel_clr;         // Front panel reset
	wire [9:0]  alarm_src;         // Ten groupable self-supervision alarms
	reg  [15:0] diag_low_r;        // Latched output fault low
	reg  [15:0] diag_high_r;       // Latched output fault high
	reg  [15:0] diag_int_r;        // Latched internal faults
	reg  [2:0]  group_act;         // Group activity
	reg         temp_fault_r;      // Temporary fault state last cycle
	reg         perm_fault_r;      // Permanent inoperative latch
	wire        wd_permanent;      // Watchdog permanent fault
	wire        temp_fault;        // Any live fault
	wire        fail_blocked;      // A linked group holds the fail contact off
	wire        fault_rise;        // Temporary fault just appeared
	wire        fault_fall;        // Temporary fault just cleared

	// Synchroniser vector layout, highest field first
	assign raw_in = {PANEL_RESET,  // 46
		PASSWORD_OPEN,             // 45
		PORT_TWO_DOWN,             // 44
		PORT_ONE_DOWN,             // 43
		EXT_IO_LINK_DOWN,          // 42
		REMOTE_LINK_DOWN,          // 41
		MAIN_FUNC_LOST,            // 40
		BOOT_TEST_FAIL,            // 39
		INTERNAL_FAULT,            // 38 down to 29
		ALARM_FAULT,               // 28 down to 24
		TRIP_FAULT};               // 23 down to 0

	// Field views of the second stage
	assign trip_f     = sync2_r[23:0];
	assign alarm_f    = sync2_r[28:24];
	assign int_f      = sync2_r[38:29];
	assign boot_fail  = sync2_r[39];
	assign main_lost  = sync2_r[40];
	assign link_alarm = sync2_r[45:41];
	assign panel_clr  = sync2_r[46];

	// Groupable alarms: five link alarms, then five classes of detected faults.
	// Whole classes are grouped rather than single bits, which keeps the
	// selection word at two bits per source instead of two per fault bit.
	// Source order, lowest first: remote, extension, port one, port two,
	// password, boot test, alarm outputs, trip outputs, internal low, high
	assign alarm_src = {|int_f[9:5], |int_f[4:0], |trip_f, |alarm_f, boot_fail,
		link_alarm};

	// Group selection of alarm n sits in ALARM_GROUP_SEL[2n+1:2n]
	// Unused selection code zero leaves an alarm out of every group
	function [2:0] group_hits;
		input [9:0] alarms;
		input [29:0] sel;
		integer k;
		begin
			group_hits = 3'h0;
			for (k = 0; k < 10; k = k + 1)
			begin
				if (alarms[k] && sel[2*k +: 2] == `GROUP_ONE)
					group_hits[0] = 1'b1;
				if (alarms[k] && sel[2*k +: 2] == `GROUP_TWO)
					group_hits[1] = 1'b1;
				if (alarms[k] && sel[2*k +: 2] == `GROUP_THREE)
					group_hits[2] = 1'b1;
			end
		end
	endfunction

	// Sticky latch step: a fault present in the clear cycle still sets the bit,
	// so a panel reset can never hide a fault that is live at that moment
	function [15:0] latch_step;
		input [15:0] held;
		input        clr;
		input [15:0] live;
		begin
			latch_step = (clr ? 16'h0000 : held) | live;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser on every pin input
	// Both stages reset to zero, the idle level of every pin, so no false
	// fault edge or panel clear follows the release of reset
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			sync1_r <= 47'h0;
			sync2_r <= 47'h0;
		end
		else
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	// The kick comes from logic on this clock, so it skips the synchroniser.
	// The panel clear is the only way out of the dead state; a later kick
	// alone never revives a controller that has once failed its restart.
	watchdog_supervisor #(
		.TIMEOUT_CYC (TIMEOUT_CYC),
		.RECOVER_CYC (RECOVER_CYC)
	) u_wd (
		.clk         (SYS_CLK),
		.rst         (RST),
		.kick        (CPU_KICK),
		.clear       (panel_clr),
		.restart_r   (CPU_RESTART),
		.permanent_r (wd_permanent)
	);

	// Any live detected fault marks a temporary inoperative state; a boot
	// self-test failure holds it for as long as its pin stays up
	assign temp_fault = (|trip_f) | (|alarm_f) | (|int_f) | boot_fail;

	////////////////////////////////////////////////////////////////////////////////
	// Alarm grouping: each source joins at most one of the three groups
	always @*
	begin
		group_act = group_hits(alarm_src, ALARM_GROUP_SEL);
	end

	// Fail contact is held off while any linked group is active
	assign fail_blocked = |(group_act & FAIL_LINK);

	////////////////////////////////////////////////////////////////////////////////
	// Fail-link configuration register
	// Defaults restore group two only, which matches fixed older wiring;
	// a defaults request beats a write that falls in the same cycle
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			FAIL_LINK <= `FAIL_LINK_DEFAULT;
		else if (CFG_LOAD_DEFAULTS)
			FAIL_LINK <= `FAIL_LINK_DEFAULT;
		else if (FAIL_LINK_WE)
			FAIL_LINK <= FAIL_LINK_SET;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Diagnostic latches; a new fault wins over a panel clear
	// Output fault bits are packed in the two register layouts here, so the
	// read port only selects and never rearranges bits
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			diag_low_r   <= 16'h0000;
			diag_high_r  <= 16'h0000;
			diag_int_r   <= 16'h0000;
			perm_fault_r <= 1'b0;
		end
		else
		begin
			diag_low_r   <= latch_step(diag_low_r, panel_clr,
				{trip_f[8], alarm_f, trip_f[7:0], 2'b00});
			diag_high_r  <= latch_step(diag_high_r, panel_clr,
				{1'b0, trip_f[23:9]});
			diag_int_r   <= latch_step(diag_int_r, panel_clr,
				{6'h00, int_f});
			// Permanent state: lost main functions or a failed restart
			perm_fault_r <= (panel_clr ? 1'b0 : perm_fault_r) | main_lost | wd_permanent;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, indicators and alarm signals
	// Every output leaves a flip-flop, so contacts never see decode glitches
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			// Everything starts de-energized until the first healthy edge
			OUT_DRIVE              <= 33'h0;
			FAIL_INDICATION_OUTPUT <= 1'b0;
			SERVICE_LED            <= 1'b0;
			FAULT_MESSAGE          <= 1'b0;
			ALARM_SIGNALS          <= 9'h000;
		end
		else
		begin
			// Permanent fault blocks every output; group maps add drives.
			// The fail contact is not part of this vector; perm_fault_r drops it on its own below.
			if (perm_fault_r)
				OUT_DRIVE <= 33'h0;
			else
				OUT_DRIVE <= OUT_REQUEST |
					({33{group_act[0]}} & GROUP_ONE_MAP) |
					({33{group_act[1]}} & GROUP_TWO_MAP) |
					({33{group_act[2]}} & GROUP_THREE_MAP);
			// Working-current principle: energized unless a permanent fault or a linked group is active
			FAIL_INDICATION_OUTPUT <= ~perm_fault_r & ~fail_blocked;
			// Service lamp covers both permanent and temporary faults
			SERVICE_LED   <= perm_fault_r | temp_fault;
			// The fault message is kept for the permanent state alone, so a
			// passing fault does not look like a dead relay on the panel
			FAULT_MESSAGE <= perm_fault_r;
			// Alarm matrix: password, three groups, live fault, four links
			ALARM_SIGNALS <= {link_alarm[4], group_act, temp_fault,
				link_alarm[3:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault on and off events with the fault code
	// Edges of the temporary fault state
	assign fault_rise = temp_fault & ~temp_fault_r;
	assign fault_fall = ~temp_fault & temp_fault_r;

	// An event is a one-cycle pulse; code and fault code stand until the next
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			// No event is pending out of reset
			temp_fault_r     <= 1'b0;
			EVENT_VALID      <= 1'b0;
			EVENT_CODE       <= 8'h00;
			EVENT_FAULT_CODE <= 16'h0000;
		end
		else
		begin
			temp_fault_r <= temp_fault;
			// One pulse per change of the temporary fault state
			EVENT_VALID  <= fault_rise | fault_fall;
			if (fault_rise)
				EVENT_CODE <= `EVT_FAULT_ON;
			else if (fault_fall)
				EVENT_CODE <= `EVT_FAULT_OFF;
			// The internal fault code rides with each event; an off event
			// always carries zero, since no internal fault is live by then
			if (fault_rise | fault_fall)
				EVENT_FAULT_CODE <= {6'h00, int_f};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Remote read port, read only
	// Registered read: data follows the address one edge later. There is
	// no write path at all, so nothing the master sends can alter a latch.
	always @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			REG_RDATA <= 16'h0000;
		else
		begin
			case (REG_ADDR)
				`REG_OUT_FAULT_LOW:  REG_RDATA <= diag_low_r;
				`REG_OUT_FAULT_HIGH: REG_RDATA <= diag_high_r;
				`REG_INTERNAL_FAULT: REG_RDATA <= diag_int_r;
				default:             REG_RDATA <= 16'h0000;
			endcase
		end
	end

endmodule // self_supervision

// >>> test/self_supervision_checker.sv
`timescale 1ns/1ps
`include "self_diag_defs.vh"
////////////////////////////////////////
// Port-level rules of the supervision block
module self_supervision_checker
#(
	parameter TIMEOUT_CYC = 20,
	parameter RECOVER_CYC = 50
)
(
	// Clock and reset
	input wire        SYS_CLK,
	input wire        RST,
	// Supervision outputs
	input wire        CPU_RESTART,
	input wire [32:0] OUT_DRIVE,
	input wire        FAIL_INDICATION_OUTPUT,
	input wire        SERVICE_LED,
	input wire        FAULT_MESSAGE,
	// Fail link configuration
	input wire [2:0]  FAIL_LINK,
	input wire [2:0]  FAIL_LINK_SET,
	input wire        FAIL_LINK_WE,
	input wire        CFG_LOAD_DEFAULTS,
	// Events and register port
	input wire        EVENT_VALID,
	input wire [7:0]  EVENT_CODE,
	input wire [1:0]  REG_ADDR,
	input wire [15:0] REG_RDATA
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Restart begins; it must stand long enough to reach the controller
	sequence s_restart;
		$rose(CPU_RESTART);
	endsequence
	// Permanent state settled for two cycles, so outputs have had time to drop
	sequence s_perm;
		FAULT_MESSAGE && $past(FAULT_MESSAGE);
	endsequence
	a_restart_held: assert property (s_restart |-> CPU_RESTART [*8])
		else $error("restart pulse too short");
	a_perm_blocks: assert property (s_perm |-> OUT_DRIVE == 33'h0)
		else $error("outputs driven in permanent fault");
	a_perm_signals: assert property (s_perm |-> SERVICE_LED && !FAIL_INDICATION_OUTPUT)
		else $error("permanent fault indication wrong");
	a_third_zero: assert property (REG_ADDR == `REG_DIAG_THREE |=> REG_RDATA == 16'h0000)
		else $error("third register not zero");
	a_low_reserved: assert property (REG_ADDR == 2'h0 |=> REG_RDATA[1:0] == 2'h0)
		else $error("reserved low bits set");
	a_high_top: assert property (REG_ADDR == 2'h1 |=> !REG_RDATA[15])
		else $error("high register bit 15 set");
	a_int_top: assert property (REG_ADDR == 2'h3 |=> REG_RDATA[15:10] == 6'h00)
		else $error("internal register upper bits set");
	a_event_pulse: assert property (EVENT_VALID |-> (EVENT_CODE == `EVT_FAULT_ON
		|| EVENT_CODE == `EVT_FAULT_OFF) ##1 !EVENT_VALID)
		else $error("event code or pulse wrong");
	a_default_link: assert property (CFG_LOAD_DEFAULTS |=> FAIL_LINK == `FAIL_LINK_DEFAULT)
		else $error("default link not restored");
	a_link_write: assert property (FAIL_LINK_WE && !CFG_LOAD_DEFAULTS
		|=> FAIL_LINK == $past(FAIL_LINK_SET))
		else $error("link write lost");
endmodule // self_supervision_checker

// >>> test/ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Controller stand-in: heartbeat while running
module ctrl_model
(
	// Clock and control
	input  wire clk,
	input  wire run,
	input  wire restart,
	// Heartbeat
	output reg  kick
);
	reg [2:0] cnt_r = 3'h0; // Kick spacing, well inside the watchdog window
	initial kick = 1'b0;
	// A real controller is mute while held in restart, so no kick then
	always @(posedge clk)
	begin
		cnt_r <= cnt_r + 3'h1;
		kick  <= run && !restart && cnt_r == 3'h0;
	end
endmodule // ctrl_model

// >>> test/test_self_supervision.sv
`timescale 1ns/1ps
`include "self_diag_defs.vh"
////////////////////////////////////////
module test_self_supervision;
	reg         clk = 0, rst = 1, run = 1, prst = 0, ldef = 0, lwe = 0, mfl = 0, boot = 0, pw = 0;
	reg  [23:0] trip = 0;
	reg  [4:0]  alm = 0;
	reg  [9:0]  intf = 0;
	reg  [3:0]  lnk = 0;  // Remote, extension, port one, port two
	reg  [29:0] gsel = 0;
	reg  [2:0]  lset = 0;
	reg  [32:0] req = 0;
	reg  [1:0]  addr = 0;
	wire        kick, rs, fail, led, msg, ev;
	wire [32:0] drv;
	wire [8:0]  asig;
	wire [2:0]  flink;
	wire [7:0]  ecode;
	wire [15:0] rd, efc;
	reg  [15:0] ocode = 0;  // Fault code carried by the latest on event
	integer     bad_count = 0, total_checks = 0, ons = 0, offs = 0, i;
	always #12.5 clk = ~clk;
	self_supervision #(.TIMEOUT_CYC(20), .RECOVER_CYC(50)) dut (.SYS_CLK(clk), .RST(rst),
		.CPU_KICK(kick), .CPU_RESTART(rs), .TRIP_FAULT(trip), .ALARM_FAULT(alm),
		.INTERNAL_FAULT(intf), .BOOT_TEST_FAIL(boot), .MAIN_FUNC_LOST(mfl),
		.REMOTE_LINK_DOWN(lnk[0]), .EXT_IO_LINK_DOWN(lnk[1]), .PORT_ONE_DOWN(lnk[2]),
		.PORT_TWO_DOWN(lnk[3]), .PASSWORD_OPEN(pw), .PANEL_RESET(prst), .ALARM_GROUP_SEL(gsel),
		.CFG_LOAD_DEFAULTS(ldef), .FAIL_LINK_SET(lset), .FAIL_LINK_WE(lwe),
		.GROUP_ONE_MAP(33'h0_0000_0001), .GROUP_TWO_MAP(33'h0_0000_0100),
		.GROUP_THREE_MAP(33'h1_0000_0000), .OUT_REQUEST(req), .OUT_DRIVE(drv),
		.FAIL_INDICATION_OUTPUT(fail), .SERVICE_LED(led), .FAULT_MESSAGE(msg),
		.ALARM_SIGNALS(asig), .FAIL_LINK(flink), .EVENT_VALID(ev), .EVENT_CODE(ecode),
		.EVENT_FAULT_CODE(efc), .REG_ADDR(addr), .REG_RDATA(rd));
	ctrl_model cpu (.clk(clk), .run(run), .restart(rs), .kick(kick));
	// Tally logged events by code
	always @(posedge clk)
	begin
		ons  <= ons + (ev === 1'b1 && ecode === `EVT_FAULT_ON);
		offs <= offs + (ev === 1'b1 && ecode === `EVT_FAULT_OFF);
		if (ev === 1'b1 && ecode === `EVT_FAULT_ON)
			ocode <= efc;
	end
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task check(input [32:0] got, input [32:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// A bounded wait that ran out ends the run at once
	task tmo(input ok);
	begin
		check(33'(ok), 33'h1);
		if (ok !== 1'b1)
			end_sim;
	end
	endtask
	// Address stands; data answers one edge later
	task rdchk(input [1:0] a, input [15:0] exp);
	begin
		addr = a;
		tick(2);
		check(33'(rd), 33'(exp));
	end
	endtask
	task clear_panel;
	begin
		prst = 1;
		tick(1);
		prst = 0;
		tick(5);
	end
	endtask
	// Raise fault pins, read all registers, then clear from the panel
	task diag(input [23:0] t, input [4:0] a, input [9:0] n, input [15:0] lo, hi, it);
	begin
		trip = t;
		alm = a;
		intf = n;
		tick(5);
		check(33'(ocode), 33'({6'h00, n}));
		check(33'(led && !msg), 33'h1);
		rdchk(2'h0, lo);
		rdchk(2'h1, hi);
		rdchk(2'h3, it);
		rdchk(2'h2, 16'h0000);
		trip = 0;
		alm = 0;
		intf = 0;
		tick(5);
		clear_panel;
		rdchk(2'h0, 16'h0000);
		rdchk(2'h3, 16'h0000);
	end
	endtask
	initial
	begin
		tick(16);
		rst = 0;
		tick(2);
		check(33'(flink), 33'h2);
		check(33'(fail), 33'h1);
		req = 33'h1_5555_0000;
		tick(3);
		check(drv, req);
		$display("reset test done");
		diag(24'hFF_FFFF, 5'h1F, 10'h3FF, 16'hFFFC, 16'h7FFF, 16'h03FF);
		diag(24'h00_0100, 5'h01, 10'h200, 16'h8400, 16'h0000, 16'h0200);
		diag(24'h80_0201, 5'h10, 10'h001, 16'h4004, 16'h4001, 16'h0001);
		check(33'(ons == offs && ons > 0), 33'h1);
		$display("register test done");
		req = 0;
		gsel = 30'h2AAA_AAAA;
		intf = 10'h001;
		tick(6);
		check(33'(fail), 33'h0);
		check(drv, 33'h0_0000_0100);
		intf = 0;
		tick(4);
		clear_panel;
		check(33'(fail), 33'h1);
		gsel = 30'h1555_5555;
		intf = 10'h001;
		tick(6);
		check(33'(fail), 33'h1);
		check(drv, 33'h0_0000_0001);
		lset = 3'h1;
		lwe = 1;
		tick(1);
		lwe = 0;
		tick(2);
		check(33'(fail), 33'h0);
		ldef = 1;
		tick(1);
		ldef = 0;
		tick(2);
		check(33'(fail), 33'h1);
		gsel = 30'h3FFF_FFFF;
		tick(4);
		check(drv, 33'h1_0000_0000);
		intf = 0;
		gsel = 0;
		tick(4);
		clear_panel;
		lnk = 4'hF;
		pw = 1;
		tick(5);
		check(33'($countones(asig)), 33'h5);
		lnk = 0;
		pw = 0;
		$display("alarm group test done");
		run = 0;
		for (i = 0; i < 200 && rs !== 1'b1; i = i + 1) tick(1);
		tmo(rs === 1'b1);
		run = 1;
		for (i = 0; i < 1000 && rs !== 1'b0; i = i + 1) tick(1);
		tmo(rs === 1'b0);
		tick(60);
		check(33'(fail), 33'h1);
		run = 0;
		req = {33{1'b1}};
		for (i = 0; i < 3000 && fail !== 1'b0; i = i + 1) tick(1);
		tmo(fail === 1'b0);
		tick(3);
		check(33'(msg && led), 33'h1);
		check(drv, 33'h0);
		$display("watchdog test done");
		rst = 1;
		tick(16);
		rst = 0;
		run = 1;
		tick(2);
		check(33'(fail), 33'h1);
		mfl = 1;
		tick(6);
		check(33'(fail || !led), 33'h0);
		rst = 1;
		mfl = 0;
		tick(16);
		rst = 0;
		boot = 1;
		tick(6);
		check(33'(led), 33'h1);
		$display("main function test done");
		end_sim;
	end
endmodule // test_self_supervision
bind self_supervision self_supervision_checker #(.TIMEOUT_CYC(TIMEOUT_CYC),
	.RECOVER_CYC(RECOVER_CYC)) chk (.SYS_CLK, .RST, .CPU_RESTART, .OUT_DRIVE,
	.FAIL_INDICATION_OUTPUT, .SERVICE_LED, .FAULT_MESSAGE, .FAIL_LINK, .FAIL_LINK_SET,
	.FAIL_LINK_WE, .CFG_LOAD_DEFAULTS, .EVENT_VALID, .EVENT_CODE, .REG_ADDR, .REG_RDATA);
